//--- hw/fsq_consts.vh
`ifndef FSQ_CONSTS_VH
`define FSQ_CONSTS_VH
// ----------------------------------------------------------------
// clock and bus widths
// ----------------------------------------------------------------
`define FSQ_CLK_NS          25
`define FSQ_AW              18
`define FSQ_DW              8
// ----------------------------------------------------------------
// times in their own units
// ----------------------------------------------------------------
`define FSQ_RESET_LOW_NS    500
`define FSQ_RELEASE_READ_NS 50
`define FSQ_READY_ALG_US    20
`define FSQ_UNPROT_SETUP_US 4
`define FSQ_PROG_MAX_US     300
`define FSQ_ERASE_MAX_S     8
`define FSQ_OE_HIGH_NS      10
`define FSQ_PULSE_NS        50
// ----------------------------------------------------------------
// derived cycle counts (least rounds up, none below one)
// ----------------------------------------------------------------
`define FSQ_CYC_UP(ns) (((ns) + `FSQ_CLK_NS - 1) / `FSQ_CLK_NS)
`define FSQ_RST_LOW_CYC   `FSQ_CYC_UP(`FSQ_RESET_LOW_NS)
`define FSQ_RST_READ_CYC  `FSQ_CYC_UP(`FSQ_RELEASE_READ_NS)
`define FSQ_READY_CYC     `FSQ_CYC_UP(`FSQ_READY_ALG_US * 1000)
`define FSQ_UNPROT_CYC    `FSQ_CYC_UP(`FSQ_UNPROT_SETUP_US * 1000)
`define FSQ_PROG_TO_CYC   `FSQ_CYC_UP(`FSQ_PROG_MAX_US * 1000)
`define FSQ_ERASE_TO_CYC  (`FSQ_ERASE_MAX_S * 40000000)
`define FSQ_OE_HIGH_CYC   `FSQ_CYC_UP(`FSQ_OE_HIGH_NS)
`define FSQ_PULSE_CYC     `FSQ_CYC_UP(`FSQ_PULSE_NS)
`define FSQ_CW            32
// ----------------------------------------------------------------
// command codes and unlock addresses
// ----------------------------------------------------------------
`define FSQ_OP_READ       3'h0
`define FSQ_OP_PROG       3'h1
`define FSQ_OP_ERASE      3'h2
`define FSQ_OP_RESET      3'h3
`define FSQ_OP_UNPROT     3'h4
`define FSQ_UNL_A1        18'h00555
`define FSQ_UNL_A2        18'h002AA
`define FSQ_UNL_D1        8'hAA
`define FSQ_UNL_D2        8'h55
`define FSQ_CMD_PROG      8'hA0
`define FSQ_CMD_ERASE     8'h80
`define FSQ_CMD_SECT      8'h30
`define FSQ_TOGGLE_BIT    6
`define FSQ_SUSP_BIT      2
`define FSQ_ZERO32        32'h0
`define FSQ_ONE32         32'h1
`endif

//--- hw/fsq_timer.v
`timescale 1ns/100ps
`include "fsq_consts.vh"
// ----------------------------------------------------------------
// down counter: load a count, flag when it reaches zero
// ----------------------------------------------------------------
module fsq_timer
(
  input  wire                  clock, // system clock
  input  wire                  nrst,  // sync reset, low active
  input  wire                  load,  // load pulse
  input  wire [`FSQ_CW-1:0]    count, // cycles to wait
  output reg                   done   // high once count expired
);
  reg [`FSQ_CW-1:0] left;             // cycles still to go

  // load wins over counting so a restart is never missed
  always @(posedge clock)
  begin
    if (!nrst)
    begin
      left <= `FSQ_ZERO32;
      done <= 1'b1;
    end
    else if (load)
    begin
      left <= count;
      done <= 1'b0;
    end
    else if (left > `FSQ_ONE32)
      left <= left - `FSQ_ONE32;
    else
    begin
      left <= `FSQ_ZERO32;
      done <= 1'b1;
    end
  end
endmodule // fsq_timer

//--- hw/fsq_host.v
`timescale 1ns/100ps
`include "fsq_consts.vh"
module fsq_host
(
  input  wire                clock,       // 40 MHz clock
  input  wire                nrst,        // sync reset, low active
  input  wire                req,         // start an operation
  input  wire [2:0]          op,          // operation code
  input  wire [`FSQ_AW-1:0]  addr,        // byte or sector address
  input  wire [`FSQ_DW-1:0]  wdata,       // program data
  output reg                 busy,        // operation in progress
  output reg                 done,        // one-cycle completion pulse
  output reg                 timeout,     // completion flag: timed out
  output reg [`FSQ_DW-1:0]   rdata,       // read data
  output reg [`FSQ_AW-1:0]   flash_a,     // flash address pins
  input  wire [`FSQ_DW-1:0]  flash_dq_i,  // flash data in
  output reg [`FSQ_DW-1:0]   flash_dq_o,  // flash data out
  output reg                 flash_dq_oe, // high while driving data
  output reg                 flash_ce_n,  // chip enable, low active
  output reg                 flash_oe_n,  // output enable, low active
  output reg                 flash_we_n,  // write enable, low active
  output reg                 flash_rst_n, // hardware reset, low active
  output reg                 unprot_hv    // raise reset to unprotect level
);
  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  localparam S_IDLE = 4'h0, S_RLOW = 4'h1, S_RREC = 4'h2, S_WR = 4'h3;
  localparam S_WGAP = 4'h4, S_RD = 4'h5, S_POLL = 4'h6, S_PGAP = 4'h7;
  localparam S_USET = 4'h8, S_POST = 4'h9;

  reg  [3:0]          state;     // sequencer state
  reg  [2:0]          wstep;     // index into write sequence
  reg  [2:0]          wlast;     // last write index
  reg  [2:0]          cur_op;    // latched op
  reg  [`FSQ_AW-1:0]  cur_a;     // latched address
  reg  [`FSQ_DW-1:0]  cur_d;     // latched data
  reg                 have_prev; // a prior poll sample exists
  reg  [`FSQ_DW-1:0]  prev;      // previous status byte
  reg                 t_load;    // step timer load
  reg  [`FSQ_CW-1:0]  t_count;   // step timer count
  wire                t_raw;     // step timer flag as registered
  wire                t_done;    // step timer expired, fresh load masked
  reg                 o_load;    // operation timeout load
  reg  [`FSQ_CW-1:0]  o_count;   // operation timeout count
  wire                o_done;    // operation timeout expired
  reg  [`FSQ_AW-1:0]  seq_a;     // address of current write step
  reg  [`FSQ_DW-1:0]  seq_d;     // data of current write step

  // ----------------------------------------------------------------
  // timers: one for pin timing, one for the operation limit
  // ----------------------------------------------------------------
  fsq_timer u_step (.clock(clock), .nrst(nrst), .load(t_load),
                    .count(t_count), .done(t_raw));
  fsq_timer u_op   (.clock(clock), .nrst(nrst), .load(o_load),
                    .count(o_count), .done(o_done));
  // the timer takes a load one edge late; without the mask its old flag
  // would end the next wait at once and cut every strobe and gap short
  assign t_done = t_raw & ~t_load;

  // write sequence table; program is four cycles, erase six
  always @*
  begin
    seq_a = `FSQ_UNL_A1;
    seq_d = `FSQ_UNL_D1;
    case (wstep)
      3'h1: begin seq_a = `FSQ_UNL_A2; seq_d = `FSQ_UNL_D2; end
      3'h2: seq_d = (cur_op == `FSQ_OP_PROG) ? `FSQ_CMD_PROG : `FSQ_CMD_ERASE;
      3'h3:
      begin
        if (cur_op == `FSQ_OP_PROG)
        begin
          seq_a = cur_a;
          seq_d = cur_d;
        end
      end
      3'h4: begin seq_a = `FSQ_UNL_A2; seq_d = `FSQ_UNL_D2; end
      3'h5: begin seq_a = cur_a; seq_d = `FSQ_CMD_SECT; end
      default: ;
    endcase
  end

  // ----------------------------------------------------------------
  // main sequencer
  // ----------------------------------------------------------------
  always @(posedge clock)
  begin
    t_load <= 1'b0;
    o_load <= 1'b0;
    done   <= 1'b0;
    if (!nrst)
    begin
      state <= S_IDLE;
      busy <= 1'b0;
      timeout <= 1'b0;
      rdata <= 8'h00;
      flash_a <= 18'h00000;
      flash_dq_o <= 8'h00;
      flash_dq_oe <= 1'b0;
      flash_ce_n <= 1'b1;
      flash_oe_n <= 1'b1;
      flash_we_n <= 1'b1;
      flash_rst_n <= 1'b1;
      unprot_hv <= 1'b0;
      wstep <= 3'h0;
      wlast <= 3'h0;
      cur_op <= 3'h0;
      cur_a <= 18'h00000;
      cur_d <= 8'h00;
      have_prev <= 1'b0;
      prev <= 8'h00;
      t_count <= `FSQ_ZERO32;
      o_count <= `FSQ_ZERO32;
    end
    else
    begin
      case (state)
        S_IDLE:
        begin
          if (req)
          begin
            busy <= 1'b1;
            timeout <= 1'b0;
            cur_op <= op;
            cur_a <= addr;
            cur_d <= wdata;
            wstep <= 3'h0;
            wlast <= (op == `FSQ_OP_PROG) ? 3'h3 : 3'h5;
            have_prev <= 1'b0;
            t_load <= 1'b1;
            case (op)
              `FSQ_OP_RESET:
              begin
                // hold low the minimum width; device aborts to array read
                flash_rst_n <= 1'b0;
                t_count <= `FSQ_RST_LOW_CYC;
                state <= S_RLOW;
              end
              `FSQ_OP_UNPROT:
              begin
                unprot_hv <= 1'b1;
                t_count <= `FSQ_UNPROT_CYC;
                state <= S_USET;
              end
              `FSQ_OP_READ:
              begin
                flash_a <= addr;
                flash_ce_n <= 1'b0;
                flash_oe_n <= 1'b0;
                t_count <= `FSQ_PULSE_CYC;
                state <= S_RD;
              end
              default:
              begin
                t_count <= `FSQ_PULSE_CYC;
                state <= S_WGAP;
              end
            endcase
          end
        end
        S_RLOW:
          if (t_done)
          begin
            flash_rst_n <= 1'b1;
            t_load <= 1'b1;
            // wait the sum of release-to-read and device recovery
            t_count <= `FSQ_READY_CYC + `FSQ_RST_READ_CYC;
            state <= S_RREC;
          end
        S_RREC:
          if (t_done)
          begin
            busy <= 1'b0;
            done <= 1'b1;
            state <= S_IDLE;
          end
        S_USET:
          if (t_done)
          begin
            // elevated level held; host may now issue writes, stays raised
            busy <= 1'b0;
            done <= 1'b1;
            state <= S_IDLE;
          end
        S_RD:
          if (t_done)
          begin
            rdata <= flash_dq_i;
            flash_ce_n <= 1'b1;
            flash_oe_n <= 1'b1;
            busy <= 1'b0;
            done <= 1'b1;
            state <= S_IDLE;
          end
        S_WGAP:
          if (t_done)
          begin
            flash_a <= seq_a;
            flash_dq_o <= seq_d;
            flash_dq_oe <= 1'b1;
            flash_ce_n <= 1'b0;
            flash_we_n <= 1'b0;
            t_load <= 1'b1;
            t_count <= `FSQ_PULSE_CYC;
            state <= S_WR;
          end
        S_WR:
          if (t_done)
          begin
            flash_we_n <= 1'b1;
            flash_ce_n <= 1'b1;
            flash_dq_oe <= 1'b0;
            t_load <= 1'b1;
            t_count <= `FSQ_PULSE_CYC;
            if (wstep == wlast)
            begin
              // completion is by polling, the limit only a safety net
              o_load <= 1'b1;
              o_count <= (cur_op == `FSQ_OP_PROG) ? `FSQ_PROG_TO_CYC
                                                  : `FSQ_ERASE_TO_CYC;
              flash_a <= cur_a;
              state <= S_PGAP;
            end
            else
            begin
              wstep <= wstep + 3'h1;
              state <= S_WGAP;
            end
          end
        S_PGAP:
          if (t_done)
          begin
            // each poll is a fresh output-enable strobe
            flash_oe_n <= 1'b0;
            flash_ce_n <= 1'b0;
            t_load <= 1'b1;
            t_count <= `FSQ_PULSE_CYC;
            state <= S_POLL;
          end
        S_POLL:
          if (t_done)
          begin
            flash_oe_n <= 1'b1;
            flash_ce_n <= 1'b1;
            prev <= flash_dq_i;
            have_prev <= 1'b1;
            t_load <= 1'b1;
            t_count <= `FSQ_PULSE_CYC + `FSQ_OE_HIGH_CYC;
            // toggle bit stopped moving: operation finished
            if (have_prev && (prev[`FSQ_TOGGLE_BIT] == flash_dq_i[`FSQ_TOGGLE_BIT]))
            begin
              rdata <= flash_dq_i;
              state <= S_POST;
            end
            else if (o_done && !o_load)
            begin
              timeout <= 1'b1;
              state <= S_POST;
            end
            else
              state <= S_PGAP;
          end
        S_POST:
          if (t_done)
          begin
            busy <= 1'b0;
            done <= 1'b1;
            state <= S_IDLE;
          end
        default: state <= S_IDLE;
      endcase
    end
  end
endmodule // fsq_host

//--- sim/fsq_host_chk.sv
`timescale 1ns/100ps
`include "fsq_consts.vh"
// ----------------------------------------------------------------
// port checker for the flash host
// ----------------------------------------------------------------
module fsq_host_chk
(
  input wire logic clock,       // system clock
  input wire logic nrst,        // sync reset, low active
  input wire logic done,        // completion pulse
  input wire logic flash_dq_oe, // data drive enable
  input wire logic flash_ce_n,  // chip enable
  input wire logic flash_oe_n,  // output enable
  input wire logic flash_we_n,  // write enable
  input wire logic flash_rst_n, // flash reset
  input wire logic unprot_hv    // unprotect level
);
  logic [15:0] low_cnt; // cycles with flash reset low
  logic [15:0] hv_cnt;  // cycles at unprotect level
  // counters saturate, so a long hold never wraps to a small value
  always_ff @(posedge clock)
  begin
    if (!nrst || flash_rst_n) low_cnt <= 16'h0000;
    else if (low_cnt != 16'hFFFF) low_cnt <= low_cnt + 16'h0001;
    if (!nrst || !unprot_hv) hv_cnt <= 16'h0000;
    else if (hv_cnt != 16'hFFFF) hv_cnt <= hv_cnt + 16'h0001;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  // write strobe stays low for at least its first two cycles with data driven
  AST_WE_PULSE: assert property ($fell(flash_we_n) |->
    (!flash_we_n && !flash_ce_n && flash_oe_n && flash_dq_oe)[*2]) else $error("bad write pulse");
  // read strobe: two cycles low with the data bus released
  AST_RD_PULSE: assert property ($fell(flash_oe_n) |->
    (!flash_oe_n && !flash_ce_n && !flash_dq_oe)[*2]) else $error("bad read pulse");
  AST_NO_FIGHT: assert property (flash_dq_oe |-> flash_oe_n) else $error("bus contention");
  AST_DONE_ONE: assert property (done |=> !done) else $error("done too long");
  AST_RST_WIDTH: assert property ($rose(flash_rst_n) |-> low_cnt >= 16'h0014)
    else $error("reset pulse short");
  AST_RST_READ: assert property ($rose(flash_rst_n) |-> flash_oe_n[*2])
    else $error("read too soon after reset");
  AST_RST_QUIET: assert property (!flash_rst_n |-> flash_we_n && flash_oe_n)
    else $error("strobe during reset");
  AST_UNPROT: assert property ($fell(flash_we_n) && unprot_hv |-> hv_cnt >= 16'h00A0)
    else $error("unprotect setup short");
  AST_OE_GAP: assert property ($rose(flash_oe_n) |-> flash_oe_n[*2])
    else $error("oe high gap short");
endmodule // fsq_host_chk

bind fsq_host fsq_host_chk fsq_host_chk_i (.clock(clock), .nrst(nrst), .done(done),
  .flash_dq_oe(flash_dq_oe), .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n),
  .flash_we_n(flash_we_n), .flash_rst_n(flash_rst_n), .unprot_hv(unprot_hv));

//--- sim/fsq_flash_model.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// behavioural flash: 16 sectors of 256 bytes
// ----------------------------------------------------------------
module fsq_flash_model
(
  input  wire logic [17:0] a,     // address pins
  input  wire logic [7:0]  dq_in, // data from host
  input  wire logic        ce_n,  // chip enable
  input  wire logic        oe_n,  // output enable
  input  wire logic        we_n,  // write enable
  input  wire logic        rst_n, // hardware reset
  input  wire logic        stuck, // algorithm never ends
  output wire logic [7:0]  dq     // data to host
);
  logic [7:0]  mem [0:4095]; // array image
  logic [17:0] pa;           // address under algorithm
  logic [7:0]  out_q;        // byte of the last read
  logic        tog;          // busy toggle state
  logic        ers;          // erase sequence entered
  int          nw;           // writes of the sequence
  int          polls;        // status reads left
  wire         rd_n = ce_n | oe_n; // read needs both strobes low
  wire         wr_n = ce_n | we_n; // write strobe
  initial
  begin
    foreach (mem[i]) mem[i] = 8'hFF;
    nw = 0;
    polls = 0;
    tog = 1'b0;
    ers = 1'b0;
    out_q = 8'h00;
  end
  // reset aborts at once and drops a half-entered sequence
  always @(negedge rst_n)
  begin
    nw = 0;
    polls = 0;
  end
  // command decoder on the end of each write
  always @(posedge wr_n)
    if (rst_n && polls == 0)
    begin
      if (nw == 3 && !ers)
      begin
        mem[a[11:0]] = mem[a[11:0]] & dq_in;
        pa = a;
        polls = 3;
        nw = 0;
      end
      else if (nw == 5 && dq_in == 8'h30)
      begin
        for (int i = 0; i < 256; i++) mem[{a[11:8], i[7:0]}] = 8'h00;
        for (int i = 0; i < 256; i++) mem[{a[11:8], i[7:0]}] = 8'hFF;
        pa = a;
        polls = 5;
        nw = 0;
      end
      else if (dq_in == ((nw == 1 || nw == 4) ? 8'h55 : (nw == 2) ? dq_in : 8'hAA))
      begin
        ers = (nw == 2) ? (dq_in == 8'h80) : ers;
        nw = nw + 1;
      end
      else nw = 0;
    end
  // status at any address while busy; suspend bit never moves
  // looked at a step after the strobe, once an address launched with it settled
  always @(negedge rd_n)
  begin
    #1;
    if (polls != 0)
    begin
      tog = ~tog;
      out_q = {~mem[pa[11:0]][7], tog, 6'h00};
      if (!stuck) polls = polls - 1;
    end
    else out_q = mem[a[11:0]];
  end
  // released bus shows the inverse, never a stale copy
  assign dq = rd_n ? ~out_q : out_q;
endmodule // fsq_flash_model

//--- sim/flash_reset_program_erase_timing_test.sv
`timescale 1ns/100ps
`include "fsq_consts.vh"
module flash_reset_program_erase_timing_test;
  logic        clock;     // bench clock
  logic        nrst;      // bench reset
  logic        req;       // start
  logic [2:0]  op;        // operation
  logic [17:0] addr;      // address
  logic [7:0]  wdata;     // program data
  logic        stuck;     // hang the flash
  wire         busy;      // operation in progress
  wire         done;      // completion
  wire         timeout;   // timed out
  wire [7:0]   rdata;     // read data
  wire [17:0]  fa;        // flash address
  wire [7:0]   dq_o;      // host data
  wire [7:0]   dq_i;      // flash data
  wire         dq_oe;     // drive enable
  wire         ce_n;      // chip enable
  wire         oe_n;      // output enable
  wire         we_n;      // write enable
  wire         rst_n;     // flash reset
  wire         hv;        // unprotect level
  int          n_fail;    // mismatches
  int          compares;  // comparisons
  fsq_host fsq_host_i (.clock(clock), .nrst(nrst), .req(req), .op(op), .addr(addr),
    .wdata(wdata), .busy(busy), .done(done), .timeout(timeout), .rdata(rdata),
    .flash_a(fa), .flash_dq_i(dq_i), .flash_dq_o(dq_o), .flash_dq_oe(dq_oe),
    .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n), .flash_rst_n(rst_n),
    .unprot_hv(hv));
  fsq_flash_model fsq_flash_model_i (.a(fa), .dq_in(dq_o), .ce_n(ce_n), .oe_n(oe_n),
    .we_n(we_n), .rst_n(rst_n), .stuck(stuck), .dq(dq_i));
  // clock at 40 MHz
  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  task automatic end_sim();
    $display("compares %0d fails %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic fail(input string msg);
    $display("[FAIL] %0t %s", $time, msg);
    n_fail++;
  endtask
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) fail($sformatf("byte %h expected %h", got, exp));
  endtask
  task automatic check1(input logic got, input logic exp);
    compares++;
    if (got !== exp) fail($sformatf("flag %b expected %b", got, exp));
  endtask
  // one operation, bounded wait for its done pulse
  task automatic run_op(input logic [2:0] o, input logic [17:0] a, input logic [7:0] d);
    int k;
    @(posedge clock);
    req <= 1'b1;
    op <= o;
    addr <= a;
    wdata <= d;
    @(posedge clock);
    req <= 1'b0;
    #1;
    check1(busy, 1'b1);
    for (k = 0; k < 20000; k++)
    begin
      @(posedge clock);
      #1;
      if (done === 1'b1) break;
    end
    if (k == 20000)
    begin
      fail("no completion");
      end_sim();
    end
    check1(busy, 1'b0);
  endtask
  // erased array after power-up, and again after an idle hardware reset
  task automatic t_idle_reset();
    run_op(3'h0, 18'h00100, 8'h00);
    check8(rdata, 8'hFF);
    run_op(3'h3, 18'h00000, 8'h00);
    run_op(3'h0, 18'h00100, 8'h00);
    check8(rdata, 8'hFF);
    $display("idle reset test done");
  endtask
  task automatic t_program();
    run_op(3'h1, 18'h00012, 8'h5A);
    check1(timeout, 1'b0);
    run_op(3'h0, 18'h00012, 8'h00);
    check8(rdata, 8'h5A);
    $display("program test done");
  endtask
  task automatic t_erase();
    run_op(3'h2, 18'h00012, 8'h00);
    check1(timeout, 1'b0);
    run_op(3'h0, 18'h00012, 8'h00);
    check8(rdata, 8'hFF);
    $display("erase test done");
  endtask
  // hung program times out, hardware reset brings the array back
  task automatic t_abort();
    stuck <= 1'b1;
    run_op(3'h1, 18'h00234, 8'hC3);
    check1(timeout, 1'b1);
    stuck <= 1'b0;
    run_op(3'h3, 18'h00000, 8'h00);
    run_op(3'h0, 18'h00234, 8'h00);
    check8(rdata, 8'hC3);
    $display("abort test done");
  endtask
  task automatic t_unprot();
    run_op(3'h4, 18'h00000, 8'h00);
    check1(hv, 1'b1);
    run_op(3'h1, 18'h00300, 8'h0F);
    run_op(3'h0, 18'h00300, 8'h00);
    check8(rdata, 8'h0F);
    $display("unprotect test done");
  endtask
  // main sequence
  initial
  begin
    nrst = 1'b0;
    req = 1'b0;
    op = 3'h0;
    addr = 18'h00000;
    wdata = 8'h00;
    stuck = 1'b0;
    n_fail = 0;
    compares = 0;
    repeat (16) @(posedge clock);
    nrst <= 1'b1;
    t_idle_reset();
    t_program();
    t_erase();
    t_abort();
    t_unprot();
    end_sim();
  end
endmodule // flash_reset_program_erase_timing_test
